// >>> core/acsel_pkg.sv
package acsel_pkg;
	localparam int   ACSEL_NCH           = 4;
	localparam int   ACSEL_RES_W         = 12;
	localparam int   ACSEL_CLK_MHZ       = 100;
	localparam int   ACSEL_CONV_NS       = 1650;
	localparam int   ACSEL_CONV_CYC      = (ACSEL_CONV_NS * ACSEL_CLK_MHZ) / 1000;
	localparam int   ACSEL_CNT_W         = 8;
	localparam logic [3:0] ACSEL_SEL_RST = 4'h0;
	localparam logic       ACSEL_STROBE_IDLE = 1'h1;
	localparam int   ACSEL_SEL_BIT_CH1   = 0;
	localparam int   ACSEL_SEL_BIT_CH4   = 3;
	localparam logic [11:0] ACSEL_BIP_FLIP = 12'h800;
	typedef enum logic [1:0] {ACSEL_IDLE, ACSEL_CONV, ACSEL_DONE} acsel_state_t;
endpackage : acsel_pkg

// >>> core/acsel_sync_if.sv
`timescale 1ns/1ps
interface acsel_sync_if;
	logic       raw;
	logic       level;
	logic       rise;
	modport sync (input raw, output level, output rise);
	modport user (output raw, input level, input rise);
endinterface : acsel_sync_if

// >>> core/acsel_sync.sv
`timescale 1ns/1ps
module acsel_sync #(
	parameter logic RST_LVL = 1'h0
) (
	input  wire logic  mclk,
	input  wire logic  sys_rst,
	acsel_sync_if.sync s
);
	typedef struct packed {
		logic [2:0] ff;
		logic       level;
	} acsel_sync_st_t;
	acsel_sync_st_t st;
	acsel_sync_st_t next_st;
	// a change counts once stages two and three agree
	always_comb begin
		next_st = st;
		next_st.ff = {st.ff[1:0], s.raw};
		if (st.ff[2] == st.ff[1])
			next_st.level = st.ff[2];
	end
	always_ff @(posedge mclk) begin
		// reset to the pin's idle level, else the first edges after reset look like a strobe
		if (sys_rst)
			st <= '{ff: {3{RST_LVL}}, level: RST_LVL};
		else
			st <= next_st;
	end
	assign s.level = st.level;
	assign s.rise  = next_st.level & ~st.level;
endmodule : acsel_sync

// >>> core/acsel_top.sv
`timescale 1ns/1ps
// Contract
// - any subset of four channels may be selected, one to all four
// - selected channels convert in ascending channel order
// - source select steers mux between select pins and register
// - source select low uses pins, high uses register
// - channel included when pin high or bit one at start rise
// - selection latched at start, held until sequence ends
// - bus bit 0 selects channel 1 up to bit 3 channel 4
// - low bus bits are inputs while read high, chip select and write low
// - register captures low bus bits on write strobe rising edge
// - busy rises at start rise and stays high through sequence
// - each channel completes 1.65 us after the previous one
// - bipolar variants give twos complement results, step fsr/4096
// - unipolar variant gives straight binary results, step fsr/4096
module acsel_top (
	input  wire logic                                mclk,
	input  wire logic                                sys_rst,
	input  wire logic                                conversion_start_n,
	input  wire logic                                source_sel_reg,
	input  wire logic [acsel_pkg::ACSEL_NCH-1:0]     hw_channel_pick,
	input  wire logic                                chip_sel_n,
	input  wire logic                                read_n,
	input  wire logic                                write_n,
	input  wire logic [3:0]                          bus_bit_in,
	input  wire logic                                unipolar,
	input  wire logic [acsel_pkg::ACSEL_RES_W-1:0]   sample_code,
	output logic                                     busy,
	output logic                                     conv_done,
	output logic [1:0]                               conv_channel,
	output logic [acsel_pkg::ACSEL_RES_W-1:0]        conv_result,
	output logic [acsel_pkg::ACSEL_NCH-1:0]          channel_select,
	output logic [acsel_pkg::ACSEL_NCH-1:0]          active_seq
);
	import acsel_pkg::*;
	////////////////////////////////////////////////////////////////////
	acsel_sync_if s_cs ();
	acsel_sync_if s_rd ();
	acsel_sync_if s_wr ();
	acsel_sync_if s_cv ();
	acsel_sync_if s_src ();
	acsel_sync_if s_pk [ACSEL_NCH] ();
	acsel_sync_if s_db [ACSEL_NCH] ();
	assign s_cs.raw  = chip_sel_n;
	assign s_rd.raw  = read_n;
	assign s_wr.raw  = write_n;
	assign s_cv.raw  = conversion_start_n;
	assign s_src.raw = source_sel_reg;
	// strobes idle high, so their synchronisers reset high: no false edge after reset
	acsel_sync #(
		.RST_LVL (ACSEL_STROBE_IDLE)
	) u_cs (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.s       (s_cs)
	);
	acsel_sync #(
		.RST_LVL (ACSEL_STROBE_IDLE)
	) u_rd (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.s       (s_rd)
	);
	acsel_sync #(
		.RST_LVL (ACSEL_STROBE_IDLE)
	) u_wr (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.s       (s_wr)
	);
	acsel_sync #(
		.RST_LVL (ACSEL_STROBE_IDLE)
	) u_cv (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.s       (s_cv)
	);
	acsel_sync u_src (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.s       (s_src)
	);
	logic [ACSEL_NCH-1:0] pick_lvl;
	logic [ACSEL_NCH-1:0] db_lvl;
	for (genvar g = 0; g < ACSEL_NCH; g++) begin : g_sync
		assign s_pk[g].raw = hw_channel_pick[g];
		assign s_db[g].raw = bus_bit_in[g];
		acsel_sync u_pk (
			.mclk    (mclk),
			.sys_rst (sys_rst),
			.s       (s_pk[g])
		);
		acsel_sync u_db (
			.mclk    (mclk),
			.sys_rst (sys_rst),
			.s       (s_db[g])
		);
		assign pick_lvl[g] = s_pk[g].level;
		assign db_lvl[g]   = s_db[g].level;
	end
	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		acsel_state_t                state;
		logic [ACSEL_NCH-1:0]        sel_reg;
		logic [ACSEL_NCH-1:0]        bus_hold;
		logic                        wr_window;
		logic [ACSEL_NCH-1:0]        seq;
		logic [1:0]                  ch;
		logic [ACSEL_CNT_W-1:0]      cnt;
		logic                        busy;
		logic                        done;
		logic [1:0]                  done_ch;
		logic [ACSEL_RES_W-1:0]      result;
	} acsel_st_t;
	acsel_st_t st;
	acsel_st_t next_st;
	logic [ACSEL_NCH-1:0] mux_sel;
	logic [ACSEL_NCH-1:0] rest;
	logic [1:0]           first_ch;
	logic [1:0]           next_ch;
	logic                 more;
	logic [ACSEL_RES_W-1:0] coded;
	////////////////////////////////////////////////////////////////////
	// source mux
	always_comb begin
		if (s_src.level)
			mux_sel = st.sel_reg;
		else
			mux_sel = pick_lvl;
	end
	// twos complement when bipolar, straight binary when unipolar
	// offset binary becomes twos complement by flipping the msb, so no adder
	always_comb begin
		if (unipolar)
			coded = sample_code;
		else
			coded = sample_code ^ ACSEL_BIP_FLIP;
	end
	always_comb begin
		first_ch = 2'd0;
		next_ch  = 2'd0;
		more     = 1'b0;
		rest     = st.seq & ~((4'h2 << st.ch) - 4'h1);
		for (int i = ACSEL_NCH - 1; i >= 0; i--) begin
			if (mux_sel[i])
				first_ch = i[1:0];
			if (rest[i]) begin
				next_ch = i[1:0];
				more    = 1'b1;
			end
		end
	end
	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;
		// bus lines are inputs in write window
		next_st.wr_window = ~s_cs.level & ~s_wr.level & s_rd.level;
		if (next_st.wr_window)
			next_st.bus_hold = db_lvl;
		if (s_wr.rise && st.wr_window)
			next_st.sel_reg = st.bus_hold;
		unique case (st.state)
			ACSEL_IDLE: begin
				// included when high at start rise
				if (s_cv.rise && (mux_sel != '0)) begin
					next_st.seq   = mux_sel;
					next_st.ch    = first_ch;
					next_st.cnt   = '0;
					next_st.busy  = 1'b1;
					next_st.state = ACSEL_CONV;
				end
			end
			ACSEL_CONV: begin
				if (st.cnt == ACSEL_CNT_W'(ACSEL_CONV_CYC - 1)) begin
					next_st.cnt     = '0;
					next_st.done    = 1'b1;
					next_st.done_ch = st.ch;
					next_st.result  = coded;
					if (more)
						next_st.ch = next_ch;
					else
						next_st.state = ACSEL_DONE;
				end else begin
					next_st.cnt = st.cnt + ACSEL_CNT_W'(1);
				end
			end
			ACSEL_DONE: begin
				next_st.busy  = 1'b0;
				next_st.seq   = '0;
				next_st.state = ACSEL_IDLE;
			end
			default: begin
				// illegal state code falls back to idle
				next_st.busy  = 1'h0;
				next_st.seq   = '0;
				next_st.state = ACSEL_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st         <= '0;
			st.state   <= ACSEL_IDLE;
			st.sel_reg <= ACSEL_SEL_RST;
		end else begin
			st <= next_st;
		end
	end
	////////////////////////////////////////////////////////////////////
	assign busy           = st.busy;
	assign conv_done      = st.done;
	assign conv_channel   = st.done_ch;
	assign conv_result    = st.result;
	assign channel_select = st.sel_reg;
	assign active_seq     = st.seq;
endmodule : acsel_top

// >>> test/acsel_chk.sv
`timescale 1ns/1ps
module acsel_chk (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic busy,
	input wire logic conv_done,
	input wire logic [1:0] conv_channel,
	input wire logic [3:0] active_seq);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_busy_seq: assert property (busy == (active_seq != 4'h0)) else $error("busy");
	a_start_seq: assert property ($rose(busy) |-> active_seq != 4'h0) else $error("empty");
	a_seq_hold: assert property (busy && $past(busy) |-> $stable(active_seq))
		else $error("moved");
	a_first_done: assert property ($rose(busy) |-> ##[162:166] conv_done) else $error("late");
	a_next_up: assert property (conv_done ##1 busy |->
		##[162:166] (conv_done && conv_channel > $past(conv_channel))) else $error("order");
	a_done_gap: assert property (conv_done |=> !conv_done) else $error("long");
	a_in_seq: assert property (conv_done |-> active_seq[conv_channel]) else $error("stray");
	a_busy_end: assert property ($fell(busy) |-> $past(conv_done)) else $error("early");
endmodule : acsel_chk
bind acsel_top acsel_chk chk (.mclk, .sys_rst, .busy, .conv_done, .conv_channel, .active_seq);

// >>> test/acsel_host.sv
`timescale 1ns/1ps
module acsel_host (
	input wire logic mclk,
	output logic conversion_start_n,
	output logic chip_sel_n,
	output logic write_n,
	output logic read_n,
	output logic [3:0] bus_bit);
	initial {conversion_start_n, chip_sel_n, write_n, read_n, bus_bit} = 8'hf5;
	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : hold
	task automatic wr(input logic [3:0] v, input logic rd);
		{chip_sel_n, write_n, read_n, bus_bit} = {2'h0, rd, v};
		hold(8);
		write_n = 1'b1;
		hold(6);
		// released lines flip so stale data never passes
		{chip_sel_n, read_n, bus_bit} = {2'h3, ~v};
		hold(2);
	endtask : wr
	task automatic go();
		conversion_start_n = 1'b0;
		hold(6);
		conversion_start_n = 1'b1;
		hold(1);
	endtask : go
endmodule : acsel_host

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0, sys_rst = 1'b1, src = 1'b1, unip = 1'b0;
	logic st_n, cs_n, wr_n, rd_n, busy, done;
	logic [1:0] ch;
	logic [3:0] pick = 4'hf, bus, csel, seq;
	logic [11:0] code = 12'h123, res;
	int num_errors = 0, tests_run = 0;
	acsel_host host (.mclk, .conversion_start_n(st_n), .chip_sel_n(cs_n), .write_n(wr_n),
		.read_n(rd_n), .bus_bit(bus));
	acsel_top DUT (.mclk, .sys_rst, .conversion_start_n(st_n), .source_sel_reg(src),
		.hw_channel_pick(pick), .chip_sel_n(cs_n), .read_n(rd_n), .write_n(wr_n),
		.bus_bit_in(bus), .unipolar(unip), .sample_code(code), .busy, .conv_done(done),
		.conv_channel(ch), .conv_result(res), .channel_select(csel), .active_seq(seq));
	initial forever #5 mclk = ~mclk;
	task automatic check(input logic [11:0] seen, exp);
		tests_run++;
		num_errors += int'(seen !== exp);
		if (seen !== exp)
			$display("[FAIL] %0t got %h exp %h", $time, seen, exp);
	endtask : check
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic run(input logic [3:0] m, np);
		host.go();
		for (int c = 0; c < 4; c++)
			if (m[c]) begin
				for (int n = 0; n < 400 && (n == 0 || done !== 1'b1); n++)
					host.hold(1);
				check(done, 1'b1); // done seen within 400 cycles
				if (done !== 1'b1)
					end_of_test();
				check(ch, 12'(c)); // order
				check(res, unip ? code : code - 12'h800); // coding
				pick = np;
			end
	endtask : run
	initial begin
		host.hold(20);
		sys_rst = 1'b0;
		host.wr(4'hd, 1'h1);
		check(csel, 4'hd); // write lands
		run(4'hd, 4'hf); // register picks
		$display("register source test ended");
		host.wr(4'h2, 1'h0);
		check(csel, 4'hd); // read low refused
		{src, unip, code} = {2'b01, 12'h9ab};
		run(4'hf, 4'h0); // pins, change ignored
		check(csel, 4'hd); // kept
		$display("pin source test ended");
		host.go();
		host.hold(8);
		check(busy, 1'h0); // empty pick refused
		pick = 4'h6;
		host.go();
		host.hold(20);
		check(busy, 1'h1); // busy in sequence
		sys_rst = 1'h1;
		host.hold(4);
		sys_rst = 1'h0;
		check({busy, seq, csel}, 9'h000); // reset clears
		$display("refusal and reset test ended");
		pick = 4'h8;
		run(4'h8, 4'h8); // single channel
		$display("single channel test ended");
		end_of_test();
	end
endmodule : tb_top
